/* File: mmv_pkg.sv */
// Shared constants and the state type of the monitor mode and voltage interrupt block.
// Assumes one clock domain and byte addressing on the register bus.
`default_nettype none

package mmv_pkg;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam int MMV_ADDR_W = 10;
  localparam logic [7:0] MMV_IDX_LOCK = 8'h70;
  localparam logic [7:0] MMV_IDX_STATUS = 8'h71;
  localparam logic [7:0] MMV_IDX_MASK = 8'h72;
  localparam logic [7:0] MMV_IDX_SFC = 8'h7C;
  localparam logic [7:0] MMV_IDX_VIE = 8'h7E;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0] MMV_SFC_RESET = 8'h40;
  localparam logic [7:0] MMV_VIE_RESET = 8'hEC;
  localparam logic [7:0] MMV_MASK_RESET = 8'h00;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int MMV_SFC_LOW_POWER = 0;
  localparam int MMV_SFC_MONITOR = 1;
  localparam int MMV_SFC_GLOBAL_IRQ = 2;
  localparam int MMV_SFC_AVG_LSB = 5;
  localparam int MMV_SFC_AVG_MSB = 7;
  localparam int MMV_VIE_GROUP = 0;
  localparam int MMV_VIE_PROCESSOR = 3;
  localparam int MMV_VIE_MAIN = 7;
  localparam int MMV_LOCK_BIT = 0;
  localparam logic [7:0] MMV_STATUS_VALID = 8'h88;

  // ****************************************************************
  // Samples per reading produced by the averaging decoder.
  // ****************************************************************
  localparam logic [7:0] MMV_AVG_1 = 8'h01;
  localparam logic [7:0] MMV_AVG_8 = 8'h08;
  localparam logic [7:0] MMV_AVG_16 = 8'h10;
  localparam logic [7:0] MMV_AVG_32 = 8'h20;
  localparam logic [7:0] MMV_AVG_128 = 8'h80;

  // Registered state of the top module; status, mask and irq live in mmv_status_irq.
  typedef struct packed {
    logic [7:0] special_function_control;
    logic [7:0] voltage_interrupt_enable;
    logic lock;
    logic waitrequest;
    logic [31:0] readdata;
    logic low_power_select;
    logic monitor_scheme_select;
    logic [7:0] avg_remote;
    logic [7:0] avg_internal;
    logic [7:0] avg_voltage;
    logic int_n;
  } mmv_top_state_t;

endpackage

`default_nettype wire

/* File: mmv_avg_decode.sv */
// Priority decoder from the averaging select field to samples per reading.
// Assumes a purely combinational use; the caller registers the outputs.
`default_nettype none

module mmv_avg_decode
  import mmv_pkg::*;
(
  input wire logic [2:0] averaging_select,
  output logic [7:0] avg_remote,
  output logic [7:0] avg_internal,
  output logic [7:0] avg_voltage
);

  // ****************************************************************
  // Decoder.
  // ****************************************************************
  // RQ7 priority decode
  // The top bit wins over the two below it, then the middle bit.
  always_comb
  begin
    // RQ8 top bit 32
    if (averaging_select[2])
    begin
      avg_remote = MMV_AVG_32;
      avg_internal = MMV_AVG_32;
      avg_voltage = MMV_AVG_32;
    end
    else if (averaging_select[1])
    begin
      avg_remote = MMV_AVG_16;
      avg_internal = MMV_AVG_16;
      avg_voltage = MMV_AVG_16;
    end
    // RQ9 low codes decode
    else if (averaging_select[0])
    begin
      avg_remote = MMV_AVG_16;
      avg_internal = MMV_AVG_16;
      avg_voltage = MMV_AVG_1;
    end
    else
    begin
      avg_remote = MMV_AVG_128;
      avg_internal = MMV_AVG_8;
      avg_voltage = MMV_AVG_8;
    end
  end

endmodule

`default_nettype wire

/* File: mmv_status_irq.sv */
// Sticky event status with write-one-to-clear, a mask and one level interrupt.
// Assumes events and clear strobes come from logic on the same clock.
`default_nettype none

module mmv_status_irq
  import mmv_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] VALID = MMV_STATUS_VALID
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] event_set,
  input wire logic clear_strobe,
  input wire logic [WIDTH-1:0] clear_bits,
  input wire logic mask_write,
  input wire logic [WIDTH-1:0] mask_data,
  output logic [WIDTH-1:0] status,
  output logic [WIDTH-1:0] mask,
  output logic irq
);

  typedef struct packed {
    logic [WIDTH-1:0] status;
    logic [WIDTH-1:0] mask;
    logic irq;
  } mmv_irq_state_t;

  mmv_irq_state_t state;
  mmv_irq_state_t next_state;

  // ****************************************************************
  // Next state.
  // ****************************************************************
  // A set in the same cycle as its clear wins, so no event is lost.
  always_comb
  begin
    next_state = state;
    if (clear_strobe)
    begin
      next_state.status = state.status & ~clear_bits;
    end
    next_state.status = (next_state.status | event_set) & VALID;
    if (mask_write)
    begin
      next_state.mask = mask_data & VALID;
    end
    next_state.irq = |(next_state.status & next_state.mask);
  end

  // Registers the state.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign status = state.status;
  assign mask = state.mask;
  assign irq = state.irq;

  default clocking mmv_irq_cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // RQ11 set needs cause
  a_status_has_cause: assert property // RQ11
    ((|(status & ~$past(status))) |->
    ((status & ~$past(status) & ~$past(event_set)) == '0))
    else $error("Status bit rose without an enabled event.");

  a_set_beats_clear: assert property // RQ11
    ((event_set != '0) |=> ((status & $past(event_set)) == $past(event_set)))
    else $error("Event lost against a clear.");

endmodule

`default_nettype wire

/* File: mmv_ctrl.sv */
// Functional notes
// RQ1 - Lock makes both control registers read-only
// RQ2 - Bit 0 picks sleep or low power
// RQ3 - Bit 1 picks continuous or cycle monitoring
// RQ4 - Global enable bit 2 gates interrupt pin
// RQ5 - Software keeps bits 3 and 4 zero
// RQ6 - Averaging field sets samples per measurement
// RQ7 - Averaging field decoded by priority, top first
// RQ8 - Top averaging bit gives 32 samples
// RQ9 - Codes 000, 001, 01x decode as tabled
// RQ10 - Averaging field resets to binary 010
// RQ11 - Status set only for enabled channels
// RQ12 - Group bit drives pin, needs global enable
// RQ13 - Processor supply enable bit 3, resets one
// RQ14 - Main supply enable bit 7, resets one
// RQ15 - Pin stays high while global enable clear
//
// Mode control and voltage interrupt control registers behind an Avalon-MM slave.
// Assumes voltage error inputs come from monitor logic on ref_clk; no synchroniser.
`default_nettype none

module mmv_ctrl
  import mmv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [MMV_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic group_voltage_irq_enable_err_processor,
  input wire logic group_voltage_irq_enable_err_main,
  output logic low_power_select,
  output logic monitor_scheme_select,
  output logic [7:0] avg_remote,
  output logic [7:0] avg_internal,
  output logic [7:0] avg_voltage,
  output logic int_n,
  output logic irq
);

  mmv_top_state_t state;
  mmv_top_state_t next_state;

  logic [7:0] reg_index;
  logic aligned;
  logic accept;
  logic wr_low;
  logic [7:0] wbyte;
  logic hit_sfc;
  logic hit_vie;
  logic hit_lock;
  logic hit_status;
  logic hit_mask;
  logic [7:0] status;
  logic [7:0] mask;
  logic [7:0] event_set;
  logic [7:0] dec_remote;
  logic [7:0] dec_internal;
  logic [7:0] dec_voltage;

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  // A request is taken at the edge where waitrequest is already low.
  assign reg_index = avs_address[MMV_ADDR_W-1:2];
  assign aligned = (avs_address[1:0] == 2'h0);
  assign accept = (avs_read | avs_write) & ~state.waitrequest;
  assign wr_low = accept & avs_write & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];
  assign hit_sfc = aligned & (reg_index == MMV_IDX_SFC);
  assign hit_vie = aligned & (reg_index == MMV_IDX_VIE);
  assign hit_lock = aligned & (reg_index == MMV_IDX_LOCK);
  assign hit_status = aligned & (reg_index == MMV_IDX_STATUS);
  assign hit_mask = aligned & (reg_index == MMV_IDX_MASK);

  // ****************************************************************
  // Voltage events.
  // ****************************************************************
  // RQ11 channel enable gating
  // Only channels whose enable bit is set may reach the status register.
  always_comb
  begin
    event_set = 8'h00;
    // RQ13 processor channel enable
    event_set[MMV_VIE_PROCESSOR] = group_voltage_irq_enable_err_processor &
      state.voltage_interrupt_enable[MMV_VIE_PROCESSOR];
    // RQ14 main channel enable
    event_set[MMV_VIE_MAIN] = group_voltage_irq_enable_err_main & state.voltage_interrupt_enable[MMV_VIE_MAIN];
  end

  // Sticky status, mask and the level interrupt for software.
  mmv_status_irq #(
    .WIDTH(8),
    .VALID(MMV_STATUS_VALID)
  ) u_status (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .event_set(event_set),
    .clear_strobe(wr_low & hit_status),
    .clear_bits(wbyte),
    .mask_write(wr_low & hit_mask),
    .mask_data(wbyte),
    .status(status),
    .mask(mask),
    .irq(irq)
  );

  // RQ6 averaging for measurements
  // The decoder output is registered before it leaves the block.
  mmv_avg_decode u_avg (
    .averaging_select(state.special_function_control[MMV_SFC_AVG_MSB:MMV_SFC_AVG_LSB]),
    .avg_remote(dec_remote),
    .avg_internal(dec_internal),
    .avg_voltage(dec_voltage)
  );

  // ****************************************************************
  // Next state.
  // ****************************************************************
  // Fills the next state: bus handshake, register writes, mode outputs, pin.
  always_comb
  begin
    next_state = state;
    // One wait cycle per request, then waitrequest rises again.
    next_state.waitrequest = ~((avs_read | avs_write) & state.waitrequest);
    if ((avs_read | avs_write) & state.waitrequest)
    begin
      next_state.readdata = 32'h0000_0000;
      if (avs_read)
      begin
        if (hit_sfc)
        begin
          next_state.readdata[7:0] = state.special_function_control;
        end
        else if (hit_vie)
        begin
          next_state.readdata[7:0] = state.voltage_interrupt_enable;
        end
        else if (hit_lock)
        begin
          next_state.readdata[MMV_LOCK_BIT] = state.lock;
        end
        else if (hit_status)
        begin
          next_state.readdata[7:0] = status;
        end
        else if (hit_mask)
        begin
          next_state.readdata[7:0] = mask;
        end
      end
    end
    // RQ1 locked writes ignored
    if (wr_low & ~state.lock)
    begin
      if (hit_sfc)
      begin
        next_state.special_function_control = wbyte;
      end
      if (hit_vie)
      begin
        next_state.voltage_interrupt_enable = wbyte;
      end
    end
    // The lock can only be set; reset alone clears it.
    if (wr_low & hit_lock & wbyte[MMV_LOCK_BIT])
    begin
      next_state.lock = 1'b1;
    end
    // RQ2 low power select
    next_state.low_power_select = state.special_function_control[MMV_SFC_LOW_POWER];
    // RQ3 monitor scheme select
    next_state.monitor_scheme_select = state.special_function_control[MMV_SFC_MONITOR];
    next_state.avg_remote = dec_remote;
    next_state.avg_internal = dec_internal;
    next_state.avg_voltage = dec_voltage;
    // RQ4 global enable gate
    // RQ12 group and global
    // RQ15 pin high when disabled
    next_state.int_n = ~(state.special_function_control[MMV_SFC_GLOBAL_IRQ] &
      state.voltage_interrupt_enable[MMV_VIE_GROUP] & (|status));
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  // RQ10 averaging reset value
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state.special_function_control <= MMV_SFC_RESET;
      state.voltage_interrupt_enable <= MMV_VIE_RESET;
      state.lock <= 1'b0;
      state.waitrequest <= 1'b1;
      state.readdata <= 32'h0000_0000;
      state.low_power_select <= 1'b0;
      state.monitor_scheme_select <= 1'b0;
      state.avg_remote <= MMV_AVG_16;
      state.avg_internal <= MMV_AVG_16;
      state.avg_voltage <= MMV_AVG_16;
      state.int_n <= 1'b1;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs come straight from the state register.
  assign avs_readdata = state.readdata;
  assign avs_waitrequest = state.waitrequest;
  assign low_power_select = state.low_power_select;
  assign monitor_scheme_select = state.monitor_scheme_select;
  assign avg_remote = state.avg_remote;
  assign avg_internal = state.avg_internal;
  assign avg_voltage = state.avg_voltage;
  assign int_n = state.int_n;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking mmv_cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // RQ1 lock freezes registers
  a_lock_freezes_regs: assert property // RQ1
    ((state.lock & accept & avs_write) |=>
    ($stable(state.special_function_control) && $stable(state.voltage_interrupt_enable)))
    else $error("Control register changed while locked.");

  // RQ2 low power follows write
  a_low_power_write: assert property // RQ2
    ((wr_low & hit_sfc & ~state.lock) |->
    ##2 (low_power_select == $past(wbyte[MMV_SFC_LOW_POWER], 2)))
    else $error("Low power select does not follow the written bit.");

  // RQ3 monitor follows write
  a_monitor_mode_write: assert property // RQ3
    ((wr_low & hit_sfc & ~state.lock) |->
    ##2 (monitor_scheme_select == $past(wbyte[MMV_SFC_MONITOR], 2)))
    else $error("Monitor scheme select does not follow the written bit.");

  // RQ4 global enable gate
  a_global_gate_pin: assert property // RQ4
    ((~state.special_function_control[MMV_SFC_GLOBAL_IRQ]) |=> int_n)
    else $error("Interrupt pin low with global enable clear.");

  // RQ8 top bit averages
  a_avg_top_bit: assert property // RQ8
    (state.special_function_control[MMV_SFC_AVG_MSB] |=>
    (avg_remote == MMV_AVG_32 && avg_internal == MMV_AVG_32 && avg_voltage == MMV_AVG_32))
    else $error("Top averaging bit did not give 32 samples.");

  // RQ9 code zero decode
  a_avg_code_zero: assert property // RQ9
    ((state.special_function_control[MMV_SFC_AVG_MSB:MMV_SFC_AVG_LSB] == 3'h0) |=>
    (avg_remote == MMV_AVG_128 && avg_internal == MMV_AVG_8 && avg_voltage == MMV_AVG_8))
    else $error("Averaging code 000 decoded wrongly.");

  // RQ10 reset averaging field
  a_avg_reset_value: assert property // RQ10
    ($fell(sys_rst) |->
    (state.special_function_control[MMV_SFC_AVG_MSB:MMV_SFC_AVG_LSB] == 3'h2))
    else $error("Averaging field not 010 after reset.");

  // RQ12 group drives pin
  a_group_drives_pin: assert property // RQ12
    ((state.special_function_control[MMV_SFC_GLOBAL_IRQ] &
    state.voltage_interrupt_enable[MMV_VIE_GROUP] & (|status)) |=> ~int_n)
    else $error("Pending voltage error did not pull the pin low.");

  // RQ13 processor event sets
  a_processor_sets: assert property // RQ13
    ((group_voltage_irq_enable_err_processor &
    state.voltage_interrupt_enable[MMV_VIE_PROCESSOR]) |=> status[MMV_VIE_PROCESSOR])
    else $error("Processor supply error did not set its status bit.");

  // RQ14 main event blocked
  a_main_blocked: assert property // RQ14
    ((~state.voltage_interrupt_enable[MMV_VIE_MAIN] &
    ~status[MMV_VIE_MAIN]) |=> ~status[MMV_VIE_MAIN])
    else $error("Disabled main supply channel set its status bit.");

  // Bus answers within one wait cycle.
  a_bus_one_wait: assert property // bus handshake
    (((avs_read | avs_write) & avs_waitrequest) |=>
    ~avs_waitrequest)
    else $error("Bus request not answered after one wait cycle.");

  // Covers for a locked write, the pin falling, a status clear and top averaging.
  c_locked_write: cover property (state.lock & wr_low & hit_sfc);
  c_pin_asserted: cover property ($fell(int_n));
  c_status_clear: cover property (wr_low & hit_status & (|status));
  c_top_avg: cover property (state.special_function_control[MMV_SFC_AVG_MSB]);

endmodule

`default_nettype wire

/* File: mmv_host.sv */
// Host model: an Avalon-MM master that runs one transfer per start request.
// Assumes the bench raises start for one cycle and waits for done.
`default_nettype none

module mmv_host
  import mmv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic rd,
  input wire logic [MMV_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] be,
  output logic done,
  output logic [31:0] rdata,
  output logic [MMV_ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;

  // Issues a request, holds it until waitrequest is seen low, then releases.
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      done <= 1'b0;
      rdata <= 32'h0;
      avs_address <= '0;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= 32'h0;
      avs_byteenable <= 4'hF;
    end
    else
    begin
      done <= 1'b0;
      if ((avs_read || avs_write) && !avs_waitrequest)
      begin
        rdata <= avs_readdata;
        done <= 1'b1;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~avs_address; // Released address and write data lines do not keep the old value; byteenable does.
        avs_writedata <= ~avs_writedata;
      end
      else if (start && !avs_read && !avs_write && !done)
      begin
        avs_address <= addr;
        avs_read <= rd;
        avs_write <= !rd;
        avs_byteenable <= be;
        avs_writedata <= (addr == {MMV_IDX_SFC, 2'b00}) ? (wdata & ~32'h18) : wdata;
      end
    end
  end
endmodule

`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the mode control and voltage interrupt registers.
// Assumes the host model in mmv_host.sv and one 20 MHz clock.
`default_nettype none

module tb;
  import mmv_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [9:0] A_SFC = {MMV_IDX_SFC, 2'b00};
  localparam logic [9:0] A_VIE = {MMV_IDX_VIE, 2'b00};
  localparam logic [9:0] A_LOCK = {MMV_IDX_LOCK, 2'b00};
  localparam logic [9:0] A_STAT = {MMV_IDX_STATUS, 2'b00};
  localparam logic [9:0] A_MASK = {MMV_IDX_MASK, 2'b00};

  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic start = 1'b0;
  logic rd = 1'b0;
  logic [9:0] addr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] be = 4'hF;
  logic done;
  logic [31:0] rdata;
  logic [9:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic err_p = 1'b0;
  logic err_m = 1'b0;
  logic lp;
  logic mon;
  logic [7:0] av_r;
  logic [7:0] av_i;
  logic [7:0] av_v;
  logic int_n;
  logic irq;
  int failures = 0;
  int samples_checked = 0;

  // Clock of 50 ns period.
  always #25 ref_clk = ~ref_clk;

  mmv_host host (.ref_clk(ref_clk), .sys_rst(sys_rst), .start(start), .rd(rd), .addr(addr),
    .wdata(wdata), .be(be), .done(done), .rdata(rdata), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  mmv_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .group_voltage_irq_enable_err_processor(err_p), .group_voltage_irq_enable_err_main(err_m),
    .low_power_select(lp), .monitor_scheme_select(mon), .avg_remote(av_r),
    .avg_internal(av_i), .avg_voltage(av_v), .int_n(int_n), .irq(irq));

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  // Compares one value and counts the result.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // Runs one bus transfer through the host and lets outputs settle.
  task automatic xfer(input logic r, input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    start <= 1'b1;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    start <= 1'b0;
    for (n = 0; n < 20; n++)
    begin
      @(posedge ref_clk);
      #1;
      if (done === 1'b1)
        break;
    end
    if (n == 20)
      check("bus done", {31'h0, done}, 32'h1);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  // Reads a register and compares it.
  task automatic rdchk(input logic [9:0] a, input logic [7:0] exp, input string name);
    xfer(1'b1, a, 32'h0);
    check(name, rdata, {24'h0, exp});
  endtask

  // Pulses the voltage error inputs for one cycle.
  task automatic pulse(input logic p, input logic m);
    @(posedge ref_clk);
    err_p <= p;
    err_m <= m;
    @(posedge ref_clk);
    err_p <= 1'b0;
    err_m <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  // Samples per reading for remote, internal and voltage by averaging code.
  function automatic logic [23:0] avg_exp(input logic [2:0] c);
    if (c[2])
      return {MMV_AVG_32, MMV_AVG_32, MMV_AVG_32};
    if (c[1])
      return {MMV_AVG_16, MMV_AVG_16, MMV_AVG_16};
    if (c[0])
      return {MMV_AVG_16, MMV_AVG_16, MMV_AVG_1};
    return {MMV_AVG_128, MMV_AVG_8, MMV_AVG_8};
  endfunction

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  // Reset values of registers and outputs, and an unmapped read.
  task automatic t_reset;
    check("avg out", {8'h0, av_r, av_i, av_v}, {8'h0, avg_exp(3'b010)});
    check("pin", {31'h0, int_n}, 32'h1);
    rdchk(A_SFC, MMV_SFC_RESET, "sfc");
    rdchk(A_VIE, MMV_VIE_RESET, "vie");
    rdchk(10'h100, 8'h00, "unmapped");
    xfer(1'b0, A_SFC | 10'h001, 32'h01);
    be <= 4'hE;
    xfer(1'b0, A_SFC, 32'h01);
    be <= 4'hF;
    rdchk(A_SFC, MMV_SFC_RESET, "sfc kept");
    rdchk(A_SFC | 10'h001, 8'h00, "unaligned");
  endtask

  // Every averaging code and both mode bits.
  task automatic t_modes;
    logic [7:0] v;
    for (int c = 0; c < 8; c++)
    begin
      v = {c[2:0], 3'b000, c[1:0]};
      xfer(1'b0, A_SFC, {24'h0, v});
      rdchk(A_SFC, v, "sfc");
      check("avg out", {8'h0, av_r, av_i, av_v}, {8'h0, avg_exp(c[2:0])});
      check("low power", {31'h0, lp}, {31'h0, c[0]});
      check("monitor", {31'h0, mon}, {31'h0, c[1]});
    end
  endtask

  // Voltage events through enables, mask, global and group gates.
  task automatic t_irq;
    xfer(1'b0, A_SFC, 32'h40);
    xfer(1'b0, A_VIE, 32'hED);
    pulse(1'b1, 1'b0);
    rdchk(A_STAT, 8'h08, "status");
    check("pin", {31'h0, int_n}, 32'h1);
    check("irq", {31'h0, irq}, 32'h0);
    xfer(1'b0, A_MASK, 32'h88);
    check("irq", {31'h0, irq}, 32'h1);
    xfer(1'b0, A_SFC, 32'h44);
    check("pin", {31'h0, int_n}, 32'h0);
    xfer(1'b0, A_STAT, 32'h08);
    rdchk(A_STAT, 8'h00, "status");
    check("pin", {31'h0, int_n}, 32'h1);
    xfer(1'b0, A_VIE, 32'hEC);
    pulse(1'b0, 1'b1);
    rdchk(A_STAT, 8'h80, "status");
    check("pin", {31'h0, int_n}, 32'h1);
    check("irq", {31'h0, irq}, 32'h1);
    xfer(1'b0, A_STAT, 32'h80);
    xfer(1'b0, A_VIE, 32'h6D);
    pulse(1'b0, 1'b1);
    rdchk(A_STAT, 8'h00, "status");
    xfer(1'b0, A_VIE, 32'hE5);
    pulse(1'b1, 1'b0);
    rdchk(A_STAT, 8'h00, "status");
    check("pin", {31'h0, int_n}, 32'h1);
  endtask

  // Lock makes both control registers read-only; a reset in mid-run clears it.
  task automatic t_lock;
    xfer(1'b0, A_LOCK, 32'h01);
    xfer(1'b0, A_SFC, 32'hE3);
    xfer(1'b0, A_VIE, 32'h00);
    rdchk(A_SFC, 8'h44, "sfc");
    rdchk(A_VIE, 8'hE5, "vie");
    check("avg out", {8'h0, av_r, av_i, av_v}, {8'h0, avg_exp(3'b010)});
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    rdchk(A_LOCK, 8'h00, "lock");
    rdchk(A_SFC, MMV_SFC_RESET, "sfc");
    rdchk(A_MASK, 8'h00, "mask");
    xfer(1'b0, A_SFC, 32'h41);
    rdchk(A_SFC, 8'h41, "sfc");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence after four cycles of reset.
  initial
  begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_modes();
    t_irq();
    t_lock();
    tally_and_finish();
  end

  // Watchdog well beyond the expected run of about 360 cycles.
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
